// >>> logic/ulp_phy.sv
// phy-side protocol logic of the eight-bit link bus
`timescale 1ns/1ps
module ulp_phy (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// link bus
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe,
	output logic dir,
	output logic nxt,
	input wire logic stp,
	output logic clk_run,
	// analog side levels
	input wire logic [1:0] line_state,
	input wire logic [1:0] vbus_state,
	input wire logic id_state,
	input wire logic pll_lock,
	// transmitter
	output logic tx_start,
	output logic [3:0] tx_pid,
	output logic tx_nopid,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_end,
	input wire logic tx_ready,
	// receiver
	input wire logic rx_active,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data
);
	localparam int RXB = ulp_pkg::RXEND_MAX_CYC;

	function automatic logic is_ext(input logic [5:0] a);
		is_ext = (a == ulp_pkg::EXT_ADDR);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [5:0] pin_s;
	logic [4:0] prev_q;
	logic pll_ok;
	ulp_pkg::ulp_st_e st_q;
	logic dir_q;
	logic dprev_q;
	logic nxt_q;
	logic oe_q;
	logic [7:0] do_q;
	logic [7:0] addr_q;
	logic [7:0] wdat_q;
	logic crun_q;
	logic int_q;
	logic tx_start_q;
	logic [3:0] tx_pid_q;
	logic tx_nopid_q;
	logic tx_valid_q;
	logic [7:0] tx_data_q;
	logic tx_end_q;
	logic turn;
	logic take;
	logic lp_go;

	ulp_sync #(.W(6)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.d({pll_lock, id_state, vbus_state, line_state}),
		.q(pin_s)
	);

	ulp_reg_if rif ();

	ulp_regmem u_mem (
		.clk(clk),
		.rif(rif)
	);

	assign pll_ok = pin_s[5];
	// the cycle after any dir change carries no valid byte
	assign turn = dir_q ^ dprev_q;
	assign take = (st_q == ulp_pkg::ST_IDLE) && !dir_q && !turn
		&& (data_i != ulp_pkg::IDLE_BYTE);
	assign lp_go = (addr_q == ulp_pkg::FCTRL_ADDR) && !wdat_q[ulp_pkg::SUSPEND_BIT];
	// an extended read looks up the address byte while it is on the bus
	assign rif.addr = (st_q == ulp_pkg::ST_RD_ADDR) ? data_i : addr_q;
	assign rif.wdata = wdat_q;
	assign rif.we = (st_q == ulp_pkg::ST_WR_COMMIT);

	////////////////////////////////////////////////////////////////////////
	// bus ownership and command sequencing
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ulp_pkg::ST_START;
			dir_q <= 1'b1;
			nxt_q <= 1'b0;
			oe_q <= 1'b0;
			addr_q <= ulp_pkg::RST_BYTE;
			wdat_q <= ulp_pkg::RST_BYTE;
		end else begin
			oe_q <= dir_q;
			case (st_q)
			ulp_pkg::ST_START: begin
				// hold the bus until the pll is locked
				if (pll_ok) begin
					dir_q <= 1'b0;
					oe_q <= 1'b0;
					st_q <= ulp_pkg::ST_IDLE;
				end
			end
			ulp_pkg::ST_IDLE: begin
				if (rx_active) begin
					dir_q <= 1'b1;
					nxt_q <= 1'b0;
					st_q <= ulp_pkg::ST_RX;
				end else if (take) begin
					case (data_i[7:6])
					ulp_pkg::CMD_TX: begin
						nxt_q <= 1'b1;
						st_q <= ulp_pkg::ST_TXC;
					end
					ulp_pkg::CMD_WR: begin
						addr_q <= {2'h0, data_i[5:0]};
						nxt_q <= 1'b1;
						st_q <= ulp_pkg::ST_WR_ACC;
					end
					ulp_pkg::CMD_RD: begin
						addr_q <= {2'h0, data_i[5:0]};
						nxt_q <= 1'b1;
						st_q <= ulp_pkg::ST_RD_ACC;
					end
					default: st_q <= ulp_pkg::ST_IDLE;
					endcase
				end
			end
			ulp_pkg::ST_TXC: begin
				nxt_q <= tx_ready;
				st_q <= ulp_pkg::ST_TX;
			end
			ulp_pkg::ST_TX: begin
				if (stp) begin
					nxt_q <= 1'b0;
					st_q <= ulp_pkg::ST_IDLE;
				end else begin
					nxt_q <= tx_ready;
				end
			end
			ulp_pkg::ST_WR_ACC: begin
				if (is_ext(addr_q[5:0])) begin
					st_q <= ulp_pkg::ST_WR_ADDR;
				end else begin
					st_q <= ulp_pkg::ST_WR_DATA;
				end
			end
			ulp_pkg::ST_WR_ADDR: begin
				addr_q <= data_i;
				st_q <= ulp_pkg::ST_WR_DATA;
			end
			ulp_pkg::ST_WR_DATA: begin
				// the byte beside stop is idle, so data is only taken before it
				if (stp) begin
					nxt_q <= 1'b0;
					st_q <= ulp_pkg::ST_WR_COMMIT;
				end else begin
					wdat_q <= data_i;
				end
			end
			ulp_pkg::ST_WR_COMMIT: begin
				if (lp_go) begin
					dir_q <= 1'b1;
					st_q <= ulp_pkg::ST_LP;
				end else begin
					st_q <= ulp_pkg::ST_IDLE;
				end
			end
			ulp_pkg::ST_RD_ACC: begin
				if (is_ext(addr_q[5:0])) begin
					st_q <= ulp_pkg::ST_RD_ADDR;
				end else begin
					nxt_q <= 1'b0;
					dir_q <= 1'b1;
					st_q <= ulp_pkg::ST_RD_TURN;
				end
			end
			ulp_pkg::ST_RD_ADDR: begin
				addr_q <= data_i;
				nxt_q <= 1'b0;
				dir_q <= 1'b1;
				st_q <= ulp_pkg::ST_RD_TURN;
			end
			ulp_pkg::ST_RD_TURN: st_q <= ulp_pkg::ST_RD_DRIVE;
			ulp_pkg::ST_RD_DRIVE: begin
				dir_q <= 1'b0;
				oe_q <= 1'b0;
				st_q <= ulp_pkg::ST_IDLE;
			end
			ulp_pkg::ST_RX: begin
				if (!rx_active) begin
					dir_q <= 1'b0;
					oe_q <= 1'b0;
					nxt_q <= 1'b0;
					st_q <= ulp_pkg::ST_IDLE;
				end else begin
					// the turnaround is already over when this byte is on the bus
					nxt_q <= rx_valid;
				end
			end
			ulp_pkg::ST_LP: begin
				// dir stays high through start-up until the pll locks again
				if (stp) begin
					st_q <= ulp_pkg::ST_START;
				end
			end
			default: st_q <= ulp_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dprev_q <= 1'b1;
		end else begin
			dprev_q <= dir_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bytes driven to the link
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			do_q <= ulp_pkg::RST_BYTE;
		end else begin
			case (st_q)
			ulp_pkg::ST_LP: do_q <= {4'h0, int_q, 1'b0, pin_s[1:0]};
			ulp_pkg::ST_RD_TURN: do_q <= rif.rdata;
			ulp_pkg::ST_RX: do_q <= rx_valid ? rx_data : {6'h00, pin_s[1:0]};
			default: do_q <= ulp_pkg::RST_BYTE;
			endcase
		end
	end

	// interface clock runs except in low power
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			crun_q <= 1'b1;
		end else if (st_q == ulp_pkg::ST_WR_COMMIT && lp_go) begin
			crun_q <= 1'b0;
		end else if (st_q == ulp_pkg::ST_LP && stp) begin
			crun_q <= 1'b1;
		end
	end

	// low power wake indication on any line, vbus or id change
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 5'h00;
			int_q <= 1'b0;
		end else begin
			prev_q <= pin_s[4:0];
			if (st_q != ulp_pkg::ST_LP) begin
				int_q <= 1'b0;
			end else if (pin_s[4:0] != prev_q) begin
				int_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmitter steering
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_start_q <= 1'b0;
			tx_pid_q <= 4'h0;
			tx_nopid_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_data_q <= ulp_pkg::RST_BYTE;
			tx_end_q <= 1'b0;
		end else begin
			tx_start_q <= take && !rx_active && (data_i[7:6] == ulp_pkg::CMD_TX);
			if (take && data_i[7:6] == ulp_pkg::CMD_TX) begin
				tx_pid_q <= data_i[3:0];
				tx_nopid_q <= (data_i[5:0] == 6'h00);
			end
			tx_valid_q <= (st_q == ulp_pkg::ST_TX) && nxt_q && !stp;
			tx_data_q <= data_i;
			tx_end_q <= (st_q == ulp_pkg::ST_TX) && stp;
		end
	end

	assign data_o = do_q;
	assign data_oe = oe_q;
	assign dir = dir_q;
	assign nxt = nxt_q;
	assign clk_run = crun_q;
	assign tx_start = tx_start_q;
	assign tx_pid = tx_pid_q;
	assign tx_nopid = tx_nopid_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign tx_end = tx_end_q;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_clk_stop;
		!crun_q |-> st_q == ulp_pkg::ST_LP;
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock stopped outside low power");
	property p_own_bus;
		dir_q && $past(dir_q) && $past(rstn) |-> oe_q;
	endproperty
	a_own_bus: assert property (p_own_bus) else $error("bus not driven while dir high");
	property p_release;
		!dir_q |-> !oe_q;
	endproperty
	a_release: assert property (p_release) else $error("bus driven with dir low");
	property p_startup;
		(st_q == ulp_pkg::ST_START) [*2] |-> dir_q;
	endproperty
	a_startup: assert property (p_startup) else $error("dir low during start-up");
	property p_turn;
		$changed(dir_q) |-> !oe_q;
	endproperty
	a_turn: assert property (p_turn) else $error("bus driven in turnaround");
	property p_accept;
		tx_valid_q |-> $past(nxt_q) && tx_data_q == $past(data_i);
	endproperty
	a_accept: assert property (p_accept) else $error("byte forwarded without nxt");
	property p_nonzero;
		tx_start_q |-> $past(data_i) != ulp_pkg::IDLE_BYTE;
	endproperty
	a_nonzero: assert property (p_nonzero) else $error("transfer started by zero byte");
	property p_lp_pins;
		st_q == ulp_pkg::ST_LP && $past(st_q == ulp_pkg::ST_LP)
			|-> !crun_q && do_q[1:0] == $past(pin_s[1:0]);
	endproperty
	a_lp_pins: assert property (p_lp_pins) else $error("line state not shown in low power");
	property p_lp_int;
		(st_q == ulp_pkg::ST_LP && pin_s[4:0] != prev_q) ##1 (st_q == ulp_pkg::ST_LP)
			|=> do_q[ulp_pkg::LP_INT_BIT];
	endproperty
	a_lp_int: assert property (p_lp_int) else $error("no low power interrupt");
	property p_wake;
		st_q == ulp_pkg::ST_LP && stp |=> crun_q && st_q == ulp_pkg::ST_START && dir_q;
	endproperty
	a_wake: assert property (p_wake) else $error("stop did not wake interface");
	property p_dec_wr;
		take && !rx_active && data_i[7:6] == ulp_pkg::CMD_WR
			|=> st_q == ulp_pkg::ST_WR_ACC && nxt_q && addr_q == {2'h0, $past(data_i[5:0])};
	endproperty
	a_dec_wr: assert property (p_dec_wr) else $error("write command misdecoded");
	property p_pid;
		tx_start_q |-> tx_pid_q == $past(data_i[3:0])
			&& tx_nopid_q == ($past(data_i[5:0]) == 6'h00);
	endproperty
	a_pid: assert property (p_pid) else $error("pid misdecoded");
	property p_ext;
		st_q == ulp_pkg::ST_RD_ACC && is_ext(addr_q[5:0]) |=> st_q == ulp_pkg::ST_RD_ADDR && nxt_q;
	endproperty
	a_ext: assert property (p_ext) else $error("extended address byte not awaited");
	property p_retain;
		st_q == ulp_pkg::ST_LP |-> !rif.we;
	endproperty
	a_retain: assert property (p_retain) else $error("register written in low power");
	property p_rx_end;
		st_q == ulp_pkg::ST_RX && !rx_active |-> ##[1:RXB] !dir_q;
	endproperty
	a_rx_end: assert property (p_rx_end) else $error("receive end too late");
	property p_commit;
		rif.we |-> $past(stp) && !stp && !nxt_q;
	endproperty
	a_commit: assert property (p_commit) else $error("write committed before stop");
	sequence s_rd_go;
		st_q == ulp_pkg::ST_RD_TURN && $rose(dir_q);
	endsequence
	sequence s_rd_tail;
		(!nxt_q && !oe_q) ##1 (oe_q && st_q == ulp_pkg::ST_RD_DRIVE) ##1 (!dir_q && !oe_q);
	endsequence
	property p_read;
		s_rd_go |-> s_rd_tail;
	endproperty
	a_read: assert property (p_read) else $error("register read sequence broken");
endmodule

// >>> logic/ulp_pkg.sv
// shared constants, states and command codes of the phy-side bus logic
package ulp_pkg;
	// command type in bits 7:6 of a link command byte
	localparam logic [1:0] CMD_IDLE = 2'h0;
	localparam logic [1:0] CMD_TX = 2'h1;
	localparam logic [1:0] CMD_WR = 2'h2;
	localparam logic [1:0] CMD_RD = 2'h3;
	// low six bits that announce a full address byte next cycle
	localparam logic [5:0] EXT_ADDR = 6'h2F;
	localparam logic [7:0] IDLE_BYTE = 8'h00;
	// register that holds the suspend control, and its bit position
	localparam logic [7:0] FCTRL_ADDR = 8'h04;
	localparam int SUSPEND_BIT = 6;
	// bit of the bus that carries the low power interrupt indication
	localparam int LP_INT_BIT = 3;
	// register array shape
	localparam int REG_AW = 8;
	// receive end delay, in high-speed bit times, and its ceiling
	localparam int RXEND_MAX_HS = 43;
	localparam int RXEND_CEIL_HS = 63;
	localparam int HS_BIT_MHZ = 480;
	localparam int CLK_MHZ = 100;
	// longest time, rounded down to whole clock cycles
	localparam int RXEND_MAX_CYC = (RXEND_MAX_HS * CLK_MHZ) / HS_BIT_MHZ;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	typedef enum logic [3:0] {
		ST_START, ST_IDLE, ST_TXC, ST_TX, ST_WR_ACC, ST_WR_ADDR, ST_WR_DATA,
		ST_WR_COMMIT, ST_RD_ACC, ST_RD_ADDR, ST_RD_TURN, ST_RD_DRIVE, ST_RX, ST_LP
	} ulp_st_e;
endpackage

// >>> logic/ulp_reg_if.sv
// carrier between the bus protocol logic and the register array
`timescale 1ns/1ps
interface ulp_reg_if;
	logic we;
	logic [ulp_pkg::REG_AW-1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface

// >>> logic/ulp_regmem.sv
// interface register array with registered read data
`timescale 1ns/1ps
module ulp_regmem (
	// clock
	input wire logic clk,
	// access port
	ulp_reg_if.mem rif
);
	logic [7:0] mem_q [0:(1 << ulp_pkg::REG_AW)-1];
	// contents only change on an explicit write, so they survive low power
	always_ff @(posedge clk) begin
		if (rif.we) begin
			mem_q[rif.addr] <= rif.wdata;
		end
	end
	always_ff @(posedge clk) begin
		rif.rdata <= mem_q[rif.addr];
	end
endmodule

// >>> logic/ulp_sync.sv
// three-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module ulp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// raw and filtered levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// a change only counts once stage two and three agree
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					s1_q[i] <= d[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate
endmodule

// >>> tb/tb.sv
// self-checking bench for the phy-side link bus logic
`timescale 1ns/1ps
module tb;
	logic clk, rstn, stp, clk_run, dir, nxt, data_oe, pll_lock, id_state, l_oe, dir_q;
	logic tx_ready, rx_active, rx_valid, tx_start, tx_nopid, tx_valid, tx_end;
	logic [7:0] data_i, data_o, l_d, last_q, rx_data, tx_data;
	logic [3:0] tx_pid;
	logic [1:0] line_state, vbus_state;
	int fails, n_compared, n_end;
	logic [7:0] mem [int];
	logic [7:0] txq [$];
	logic [7:0] expq [$];
	logic [4:0] st_q [$];
	ulp_phy dut (.clk(clk), .rstn(rstn), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
		.dir(dir), .nxt(nxt), .stp(stp), .clk_run(clk_run), .line_state(line_state),
		.vbus_state(vbus_state), .id_state(id_state), .pll_lock(pll_lock),
		.tx_start(tx_start), .tx_pid(tx_pid), .tx_nopid(tx_nopid), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_end(tx_end), .tx_ready(tx_ready), .rx_active(rx_active),
		.rx_valid(rx_valid), .rx_data(rx_data));
	ulp_link_model link (.clk(clk), .dir(dir), .nxt(nxt), .q(data_i), .d(l_d), .oe(l_oe),
		.stp(stp));
	// a floating bus shows the inverse of its last value, never a stale command
	assign data_i = data_oe ? data_o : (l_oe && !dir && !dir_q) ? l_d : ~last_q;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) tx_ready <= 1'($urandom());
	always @(posedge clk) begin
		last_q <= data_i;
		dir_q <= dir;
		if (tx_valid === 1'b1)
			txq.push_back(tx_data);
		if (tx_start === 1'b1)
			st_q.push_back({tx_nopid, tx_pid});
		if (tx_end === 1'b1)
			n_end++;
	end
	////////////////////////////////////////
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (e !== g) begin
			fails++;
			$display("mismatch t=%0t exp=%0h got=%0h", $time, e, g);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic readback();
		logic [7:0] v;
		foreach (mem[i]) begin
			link.rd(8'(i), i > 63, v);
			chk(mem[i], v);
		end
	endtask
	initial begin
		#500000;
		fails++;
		conclude();
	end
	////////////////////////////////////////
	initial begin
		logic [7:0] a, v, pid;
		int n;
		void'($urandom(32'h9837));
		{rstn, pll_lock, rx_active, rx_valid, id_state} = 5'h00;
		{line_state, vbus_state, rx_data, last_q} = 20'h00000;
		{fails, n_compared, n_end, dir_q, tx_ready} = {32'h0, 32'h0, 32'h0, 2'h3};
		repeat (5) @(negedge clk);
		chk(8'h02, {6'h0, dir, data_oe});
		rstn = 1'b1;
		repeat (10) @(negedge clk);
		chk(8'h01, {7'h0, dir});
		pll_lock = 1'b1;
		link.start();
		// register writes, alternately immediate and extended, away from the suspend register
		for (n = 0; n < 8; n++) begin
			a = n[0] ? 8'($urandom_range(48, 255)) : {2'b00, 6'($urandom_range(5, 46))};
			v = 8'($urandom());
			link.wr(a, v, n[0]);
			mem[a] = v;
		end
		readback();
		// transmit with a packet id, then without
		for (n = 0; n < 2; n++) begin
			pid = n ? 8'h00 : {4'h0, 4'($urandom_range(1, 15))};
			expq = {};
			txq = {};
			link.put({2'b01, pid[5:0]});
			repeat (4) begin
				v = 8'($urandom());
				expq.push_back(v);
				link.put(v);
			end
			link.stop();
			repeat (3) @(negedge clk);
			chk(8'(expq.size()), 8'(txq.size()));
			foreach (expq[i])
				chk(expq[i], txq[i]);
			chk({3'h0, n[0], pid[3:0]}, {3'h0, st_q[n]});
		end
		chk(8'h02, 8'(n_end));
		// zero command with stray low bits is no transfer
		link.d = 8'h05;
		repeat (4) begin
			@(negedge clk);
			chk(8'h00, {7'h0, nxt});
		end
		link.d = 8'h00;
		// receive takes the bus over a turnaround
		rx_data = 8'($urandom());
		{rx_active, rx_valid} = 2'h3;
		@(negedge clk);
		chk(8'h02, {6'h0, dir, data_oe});
		@(negedge clk);
		chk(rx_data, data_o);
		chk(8'h03, {6'h0, nxt, data_oe});
		rx_valid = 1'b0;
		@(negedge clk);
		chk({6'h0, line_state}, data_o);
		rx_active = 1'b0;
		@(negedge clk);
		chk(8'h00, {7'h0, dir});
		link.start();
		// suspend, watch line state and interrupt, wake by stop
		link.wr(8'h04, 8'h00, 1'b0);
		line_state = 2'($urandom());
		repeat (8) @(negedge clk);
		chk(8'h01, {6'h0, clk_run, dir});
		chk({6'h0, line_state}, {6'h0, data_o[1:0]});
		id_state = 1'b1;
		repeat (8) @(negedge clk);
		chk(8'h01, {7'h0, data_o[3]});
		link.stop();
		link.start();
		chk(8'h01, {7'h0, clk_run});
		readback();
		conclude();
	end
endmodule

// >>> tb/ulp_link_model.sv
// link-side partner model driving the eight-bit bus and stop
`timescale 1ns/1ps
module ulp_link_model (
	// clock and phy outputs
	input wire logic clk,
	input wire logic dir,
	input wire logic nxt,
	input wire logic [7:0] q,
	// link drive
	output logic [7:0] d,
	output logic oe,
	output logic stp
);
	initial begin
		d = 8'h00;
		oe = 1'b0;
		stp = 1'b0;
	end
	////////////////////////////////////////
	// commands only once dir is low and its turnaround is over
	task automatic start();
		int k;
		k = 0;
		while (dir !== 1'b0 && k < 200) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		d = 8'h00;
		oe = 1'b1;
	endtask
	// byte stands until nxt is seen in its cycle; bounded so a dead phy cannot hang us
	task automatic put(input logic [7:0] b);
		int k;
		d = b;
		oe = 1'b1;
		k = 0;
		while (nxt !== 1'b1 && k < 50) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
	endtask
	// one-clock stop with idle beside it
	task automatic stop();
		d = 8'h00;
		stp = 1'b1;
		@(negedge clk);
		stp = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic ext);
		put(ext ? 8'hAF : {2'b10, a[5:0]});
		if (ext)
			put(a);
		put(v);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, input logic ext, output logic [7:0] v);
		put(ext ? 8'hEF : {2'b11, a[5:0]});
		if (ext)
			put(a);
		oe = 1'b0;
		@(negedge clk);
		v = q;
		start();
	endtask
endmodule
